// ### rtl/eit_trap.sv
// Extended instruction trap controller with fuse, lock and vector handling.
// Assumes a core that stalls on halt_o and a controller reached by Wishbone.
// Behaviour
// RL1: Emulation enabled halts core on extended opcodes
// RL2: Controller writes results before resume
// RL3: Extended opcodes never run natively, always trap
// RL4: Each trap holds for its own time
// RL5: Hold times fixed, independent of target clock
// RL6: Ignored program store traps about 1.1 ms
// RL7: Reset vector fuse zero breaks at 0x0000
// RL8: IO clock stopped throughout every trap
// RL9: Operand-free loads run natively unless enabled
// RL10: Fuse and lock reads need emulation enabled
// RL11: Variant without set breaks and warns host
// RL12: External memory access adds one cycle
// RL13: Only reset and boot fuses steer execution
// RL14: Fuses change only via host path
// RL15: Boot lock groups gate loads and stores
// RL16: Locks set by store, cleared by host
// RL17: Two words reserved per interrupt vector
// RL18: Vectors always from default table
// RL19: Restart IO clock, resume after trapped instruction
//
// Decided for this implementation: the placing of the registers and the Wishbone interface to the registers.
`default_nettype none
module eit_trap (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        fetch_i,
  input  wire logic [15:0] op_i,
  input  wire logic [15:0] pc_i,
  input  wire logic [15:0] boot_start_i,
  input  wire logic [7:0]  store_ctrl_i,
  input  wire logic [7:0]  store_lock_i,
  input  wire logic        xmem_req_i,
  input  wire logic [4:0]  irq_num_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             halt_o,
  output logic             io_clk_en_o,
  output logic             resume_o,
  output logic             xmem_wait_o,
  output logic             fuse_read_en_o,
  output logic             load_allow_o,
  output logic             store_allow_o,
  output logic [15:0]      vec_addr_o,
  output logic             irq_o
);
  // One-hot trap sequence: run, timed hold, wait for the host, resume
  typedef enum logic [3:0] {
    EIT_ST_RUN  = 4'b0001,
    EIT_ST_HOLD = 4'b0010,
    EIT_ST_WAIT = 4'b0100,
    EIT_ST_RES  = 4'b1000
  } eit_state_t;

  localparam int unsigned STEP = eit_pkg::CLK_MHZ;

  eit_state_t                state;
  eit_state_t                next_state;
  logic [31:0]               ctrl;
  logic [7:0]                fuse;
  logic [7:0]                lock;
  logic [eit_pkg::NEV-1:0]   status;
  logic [eit_pkg::NEV-1:0]   mask;
  logic [eit_pkg::NEV-1:0]   ev;
  logic [eit_pkg::CNT_W-1:0] hold_cycles;
  logic [eit_pkg::CNT_W-1:0] scale;
  logic [3:0]                trap_cls;
  logic                      timer_load;
  logic                      timer_busy;
  logic                      emu_en;
  logic                      is_ext;
  logic                      zero_hit;
  logic                      in_boot;
  logic                      store_ok;
  logic                      wb_hit;
  logic                      done_pulse;
  logic [31:0]               rd_data;
  eit_dec_if                 dec_bus ();

  eit_decode u_dec (
    .op_i (op_i),
    .dec  (dec_bus)
  );

  assign emu_en  = ctrl[eit_pkg::CTRL_EMU_EN];
  // Operand-free loads are extended only while emulation is on
  assign is_ext  = (dec_bus.cls != eit_pkg::EIT_CL_NONE) &&
                   (emu_en || (dec_bus.cls != eit_pkg::EIT_CL_LOAD0 &&
                               dec_bus.cls != eit_pkg::EIT_CL_XLOAD0)); // RL9
  assign zero_hit = fetch_i && (pc_i == 16'h0000) &&
                    !fuse[eit_pkg::FUSE_RST_SEL]; // RL7
  // Boot area bound comes from the core, which sizes it from the boot fuses
  assign in_boot = (pc_i >= boot_start_i);
  // A store from the application area or under a programmed low or high lock group is ignored
  assign store_ok = in_boot &&
                    (lock[eit_pkg::LOCK_HIGH_LO +: 2] == 2'b11) &&
                    (lock[eit_pkg::LOCK_LOW_LO +: 2] == 2'b11); // RL15 RL6

  // Hold time per class; cycles per microsecond is the clock rate in MHz
  always_comb
  begin
    hold_cycles = eit_pkg::CNT_W'(eit_pkg::T_ZERO_BREAK_US * STEP);
    case (eit_pkg::eit_class_t'(dec_bus.cls))
      eit_pkg::EIT_CL_PAIR:   hold_cycles = eit_pkg::CNT_W'(eit_pkg::T_PAIR_MOVE_US * STEP); // RL4
      eit_pkg::EIT_CL_LOAD0,
      eit_pkg::EIT_CL_LOAD:   hold_cycles = eit_pkg::CNT_W'(eit_pkg::T_LOAD_US * STEP);
      eit_pkg::EIT_CL_LOADI:  hold_cycles = eit_pkg::CNT_W'(eit_pkg::T_LOAD_INC_US * STEP);
      eit_pkg::EIT_CL_XLOAD0,
      eit_pkg::EIT_CL_XLOAD:  hold_cycles = eit_pkg::CNT_W'(eit_pkg::T_XLOAD_US * STEP);
      eit_pkg::EIT_CL_XLOADI: hold_cycles = eit_pkg::CNT_W'(eit_pkg::T_XLOAD_INC_US * STEP);
      eit_pkg::EIT_CL_MULT:   hold_cycles = eit_pkg::CNT_W'(eit_pkg::T_MULT_US * STEP);
      eit_pkg::EIT_CL_STORE:
      begin
        if (!store_ok)
          hold_cycles = eit_pkg::CNT_W'(eit_pkg::T_STORE_IGN_US * STEP); // RL6
        else if (store_ctrl_i == eit_pkg::PSC_ERASE)
          hold_cycles = eit_pkg::CNT_W'(eit_pkg::T_STORE_03_US * STEP);
        else if (store_ctrl_i == eit_pkg::PSC_WRITE)
          hold_cycles = eit_pkg::CNT_W'(eit_pkg::T_STORE_05_US * STEP);
        else if (store_ctrl_i == eit_pkg::PSC_LOCK)
          hold_cycles = eit_pkg::CNT_W'(eit_pkg::T_STORE_09_US * STEP);
        else
          hold_cycles = eit_pkg::CNT_W'(eit_pkg::T_STORE_01_US * STEP);
      end
      default:                hold_cycles = eit_pkg::CNT_W'(eit_pkg::T_ZERO_BREAK_US * STEP);
    endcase
    // A nonzero scale register replaces the count, so a bench can shorten it
    if (scale != '0)
      hold_cycles = scale;
  end

  // Fixed counts on the block clock, never derived from the target clock
  eit_timer u_timer (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .load_i    (timer_load),
    .count_i   (hold_cycles),
    .busy_o    (timer_busy)
  ); // RL5

  assign timer_load = (state == EIT_ST_RUN) && fetch_i && (is_ext || zero_hit);
  assign done_pulse = wb_hit && wb_we_i && wb_sel_i[0] &&
                      (wb_adr_i == eit_pkg::ADR_CTRL) && wb_dat_i[eit_pkg::CTRL_DONE];

  always_comb
  begin
    next_state = state;
    case (state)
      EIT_ST_RUN:  if (timer_load) next_state = EIT_ST_HOLD; // RL1 RL3
      EIT_ST_HOLD: if (!timer_busy) next_state = EIT_ST_WAIT; // RL4
      EIT_ST_WAIT: if (done_pulse) next_state = EIT_ST_RES; // RL2
      EIT_ST_RES:  next_state = EIT_ST_RUN; // RL19
      default:     next_state = EIT_ST_RUN;
    endcase
  end

  // Fetches during a trap are ignored; the core is stalled anyway
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      state <= EIT_ST_RUN;
    else if (ce_i)
      state <= next_state;
  end

  // Class of the last trap, kept for the host to read
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      trap_cls <= 4'h0;
    else if (ce_i && timer_load)
      trap_cls <= is_ext ? 4'(dec_bus.cls) : 4'h0;
  end

  // Halt and the IO clock gate cover the trap from the fetch to the resume
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      halt_o      <= 1'b0;
      io_clk_en_o <= 1'b1;
      resume_o    <= 1'b0;
    end
    else if (ce_i)
    begin
      halt_o      <= (next_state != EIT_ST_RUN); // RL1
      io_clk_en_o <= (next_state == EIT_ST_RUN); // RL8 RL19
      resume_o    <= (state == EIT_ST_RES); // RL19
    end
  end

  // One wait cycle per external access; pin timing stays with the bus unit
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      xmem_wait_o <= 1'b0;
    else if (ce_i)
      xmem_wait_o <= xmem_req_i && !xmem_wait_o; // RL12
  end

  // Permission outputs; no bit of the fuse register reaches this logic
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      fuse_read_en_o <= 1'b0;
      load_allow_o   <= 1'b1;
      store_allow_o  <= 1'b0;
      vec_addr_o     <= eit_pkg::VEC_BASE;
    end
    else if (ce_i)
    begin
      fuse_read_en_o <= emu_en; // RL10
      load_allow_o   <= in_boot ? lock[eit_pkg::LOCK_HIGH_LO + 1]
                                : lock[eit_pkg::LOCK_LOW_LO + 1]; // RL15 RL13
      store_allow_o  <= store_ok; // RL15
      vec_addr_o     <= eit_pkg::VEC_BASE +
                        16'(irq_num_i) * 16'(eit_pkg::VEC_WORDS); // RL17 RL18
    end
  end

  // Status events: trap, zero break, unsupported variant for the host warning, resume
  assign ev[eit_pkg::EV_TRAP]   = timer_load && is_ext && ctrl[eit_pkg::CTRL_VARIANT_EXT];
  assign ev[eit_pkg::EV_ZERO]   = timer_load && zero_hit;
  assign ev[eit_pkg::EV_UNSUP]  = timer_load && is_ext && !ctrl[eit_pkg::CTRL_VARIANT_EXT]; // RL11
  assign ev[eit_pkg::EV_RESUME] = (state == EIT_ST_RES);

  // Ack gates the hit, so a held request is taken only once
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Done is a strobe and is never stored
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      ctrl <= 32'h0000_0000;
    else if (ce_i && wb_hit && wb_we_i && wb_sel_i[0] && wb_adr_i == eit_pkg::ADR_CTRL)
      ctrl <= {30'h0, wb_dat_i[eit_pkg::CTRL_VARIANT_EXT:eit_pkg::CTRL_EMU_EN]};
  end

  // Fuses only from the host; program stores never touch them
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      fuse <= eit_pkg::FUSE_RESET;
    else if (ce_i && wb_hit && wb_we_i && wb_sel_i[0] && wb_adr_i == eit_pkg::ADR_FUSE)
      fuse <= wb_dat_i[7:0]; // RL14
  end

  // Lock bits: host writes set any value, a lock store can only program
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      lock <= eit_pkg::LOCK_RESET;
    else if (ce_i)
    begin
      if (wb_hit && wb_we_i && wb_sel_i[0] && wb_adr_i == eit_pkg::ADR_LOCK)
        lock <= wb_dat_i[7:0]; // RL16
      else if (timer_load && is_ext && dec_bus.cls == eit_pkg::EIT_CL_STORE &&
               store_ok && store_ctrl_i == eit_pkg::PSC_LOCK)
        lock <= lock & store_lock_i; // RL16
    end
  end

  // Scale ignores byte selects; when nonzero it replaces every hold count, longer or shorter
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      scale <= '0;
    else if (ce_i && wb_hit && wb_we_i && wb_adr_i == eit_pkg::ADR_SCALE)
      scale <= wb_dat_i[eit_pkg::CNT_W-1:0];
  end

  // Mask shares the status layout
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      mask <= '0;
    else if (ce_i && wb_hit && wb_we_i && wb_sel_i[0] && wb_adr_i == eit_pkg::ADR_MASK)
      mask <= wb_dat_i[eit_pkg::NEV-1:0];
  end

  // Write one to clear; a new event in the same cycle wins
  for (genvar i = 0; i < eit_pkg::NEV; i++)
  begin : g_stat
    always_ff @(posedge ref_clk_i)
    begin
      if (rst_i)
        status[i] <= 1'b0;
      else if (ce_i)
      begin
        if (ev[i])
          status[i] <= 1'b1;
        else if (wb_hit && wb_we_i && wb_sel_i[0] && wb_adr_i == eit_pkg::ADR_STATUS &&
                 wb_dat_i[i])
          status[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else if (ce_i)
      irq_o <= |(status & mask);
  end

  // Reads decode the address alone; unmapped offsets return zero
  always_comb
  begin
    rd_data = 32'h0000_0000;
    case (wb_adr_i)
      eit_pkg::ADR_CTRL:   rd_data = ctrl;
      eit_pkg::ADR_STATUS: rd_data = {28'h0, status};
      eit_pkg::ADR_MASK:   rd_data = {28'h0, mask};
      eit_pkg::ADR_FUSE:   rd_data = {24'h0, fuse};
      eit_pkg::ADR_LOCK:   rd_data = {24'h0, lock};
      eit_pkg::ADR_TRAP:   rd_data = {24'h0, trap_cls, state};
      eit_pkg::ADR_SCALE:  rd_data = {8'h0, scale};
      default:             rd_data = 32'h0000_0000;
    endcase
  end

  // One-cycle answer; unmapped addresses ack and read zero
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= wb_hit ? rd_data : 32'h0000_0000;
    end
  end
endmodule : eit_trap
`default_nettype wire

// ### rtl/eit_pkg.sv
// Constants shared by the extended instruction trap block.
// Assumes a single 250 MHz clock domain and classic Wishbone registers.
`default_nettype none
package eit_pkg;
  localparam int          CLK_MHZ          = 250;
  // Hold times in microseconds, as printed in tenths of a millisecond
  localparam int          T_PAIR_MOVE_US   = 3400;
  localparam int          T_LOAD_US        = 3600;
  localparam int          T_LOAD_INC_US    = 3800;
  localparam int          T_XLOAD_US       = 4600;
  localparam int          T_XLOAD_INC_US   = 4900;
  localparam int          T_MULT_US        = 5800;
  localparam int          T_STORE_01_US    = 5700;
  localparam int          T_STORE_03_US    = 11500;
  localparam int          T_STORE_05_US    = 26800;
  localparam int          T_STORE_09_US    = 2400;
  localparam int          T_STORE_IGN_US   = 1100;
  localparam int          T_ZERO_BREAK_US  = 800;
  // Wishbone register byte offsets
  localparam logic [7:0]  ADR_CTRL         = 8'h00;
  localparam logic [7:0]  ADR_STATUS       = 8'h04;
  localparam logic [7:0]  ADR_MASK         = 8'h08;
  localparam logic [7:0]  ADR_FUSE         = 8'h0c;
  localparam logic [7:0]  ADR_LOCK         = 8'h10;
  localparam logic [7:0]  ADR_TRAP         = 8'h14;
  localparam logic [7:0]  ADR_SCALE        = 8'h18;
  // Control fields
  localparam int          CTRL_EMU_EN      = 0;
  localparam int          CTRL_VARIANT_EXT = 1;
  localparam int          CTRL_DONE        = 2;
  // Fuse fields
  localparam int          FUSE_RST_SEL     = 0;
  localparam int          FUSE_BOOT_LO     = 1;
  localparam int          FUSE_BOOT_W      = 2;
  localparam logic [7:0]  FUSE_RESET       = 8'hff;
  // Lock fields: general 1:0, low group 3:2, high group 5:4; 1 = unprogrammed
  localparam int          LOCK_LOW_LO      = 2;
  localparam int          LOCK_HIGH_LO     = 4;
  localparam logic [7:0]  LOCK_RESET       = 8'hff;
  // Status bits
  localparam int          NEV              = 4;
  localparam int          EV_TRAP          = 0;
  localparam int          EV_ZERO          = 1;
  localparam int          EV_UNSUP         = 2;
  localparam int          EV_RESUME        = 3;
  // Program store control codes
  localparam logic [7:0]  PSC_FILL         = 8'h01;
  localparam logic [7:0]  PSC_ERASE        = 8'h03;
  localparam logic [7:0]  PSC_WRITE        = 8'h05;
  localparam logic [7:0]  PSC_LOCK         = 8'h09;
  // Instruction classes from the decoder
  typedef enum logic [3:0] {
    EIT_CL_NONE, EIT_CL_PAIR, EIT_CL_LOAD0, EIT_CL_LOAD, EIT_CL_LOADI,
    EIT_CL_XLOAD0, EIT_CL_XLOAD, EIT_CL_XLOADI, EIT_CL_MULT, EIT_CL_STORE
  } eit_class_t;
  localparam int          CNT_W            = 24;
  localparam int          WORD_W           = 16;
  localparam logic [15:0] VEC_BASE         = 16'h0000;
  localparam int          VEC_WORDS        = 2;
endpackage : eit_pkg
`default_nettype wire

// ### rtl/eit_dec_if.sv
// Decoder result carried from the opcode classifier to the trap controller.
// Assumes both ends share one clock.
`default_nettype none
interface eit_dec_if;
  eit_pkg::eit_class_t cls;
  modport dec (output cls);
  modport ctl (input  cls);
endinterface : eit_dec_if
`default_nettype wire

// ### rtl/eit_decode.sv
// Opcode classifier for the extended instruction set.
// Assumes a valid fetched word at its input.
`default_nettype none
module eit_decode (
  input  wire logic [15:0] op_i,
  eit_dec_if.dec           dec
);
  always_comb
  begin
    dec.cls = eit_pkg::EIT_CL_NONE;
    if (op_i[15:8] == 8'h01)
      dec.cls = eit_pkg::EIT_CL_PAIR;
    else if (op_i[15:10] == 6'h27 || op_i[15:8] == 8'h02 || op_i[15:8] == 8'h03)
      dec.cls = eit_pkg::EIT_CL_MULT;
    else if (op_i == 16'h95c8)
      dec.cls = eit_pkg::EIT_CL_LOAD0;
    else if (op_i == 16'h95d8)
      dec.cls = eit_pkg::EIT_CL_XLOAD0;
    else if (op_i == 16'h95e8)
      dec.cls = eit_pkg::EIT_CL_STORE;
    else if (op_i[15:9] == 7'h48)
    begin
      case (op_i[3:0])
        4'h4:    dec.cls = eit_pkg::EIT_CL_LOAD;
        4'h5:    dec.cls = eit_pkg::EIT_CL_LOADI;
        4'h6:    dec.cls = eit_pkg::EIT_CL_XLOAD;
        4'h7:    dec.cls = eit_pkg::EIT_CL_XLOADI;
        default: dec.cls = eit_pkg::EIT_CL_NONE;
      endcase
    end
  end
endmodule : eit_decode
`default_nettype wire

// ### rtl/eit_timer.sv
// Hold timer: loads a cycle count and reports when it has run out.
// Assumes the count is at least one cycle.
`default_nettype none
module eit_timer (
  input  wire logic                     ref_clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     ce_i,
  input  wire logic                     load_i,
  input  wire logic [eit_pkg::CNT_W-1:0] count_i,
  output logic                          busy_o
);
  logic [eit_pkg::CNT_W-1:0] remain;
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      remain <= '0;
    else if (ce_i)
    begin
      if (load_i)
        remain <= count_i;
      else if (remain != '0)
        remain <= remain - 1'b1;
    end
  end
  assign busy_o = (remain != '0);
endmodule : eit_timer
`default_nettype wire

// ### sim/eit_trap_sva.sv
// Port checker for the trap controller: halt, resume, wait and vector timing.
// Assumes ce_i high and a scaled hold of at least eight cycles.
`default_nettype none
module eit_trap_sva (
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  input wire logic        fetch_i,
  input wire logic [15:0] op_i,
  input wire logic [15:0] pc_i,
  input wire logic        xmem_req_i,
  input wire logic [4:0]  irq_num_i,
  input wire logic        halt_o,
  input wire logic        io_clk_en_o,
  input wire logic        resume_o,
  input wire logic        xmem_wait_o,
  input wire logic        fuse_read_en_o,
  input wire logic [15:0] vec_addr_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_ext_fetch;
    fetch_i && !halt_o && fuse_read_en_o && (op_i[15:8] == 8'h01 || op_i[15:10] == 6'h27);
  endsequence
  sequence s_plain_load;
    fetch_i && !halt_o && !fuse_read_en_o && op_i == 16'h95c8 && pc_i != 16'h0000;
  endsequence
  sequence s_release;
    resume_o && !halt_o && io_clk_en_o;
  endsequence
  chk_ext_halts: assert property (s_ext_fetch |=> halt_o)
    else $error("extended opcode did not halt");
  chk_plain_load: assert property (s_plain_load |=> !halt_o)
    else $error("plain load trapped");
  chk_io_stopped: assert property (io_clk_en_o == !halt_o)
    else $error("io clock enable not inverse of halt");
  chk_hold_min: assert property ($rose(halt_o) |=> halt_o [*8])
    else $error("halt released too early");
  chk_resume_bound: assert property ($rose(halt_o) |-> ##[1:1000] s_release)
    else $error("no resume after trap");
  chk_resume_pulse: assert property (resume_o |-> !halt_o ##1 !resume_o)
    else $error("resume not a single pulse");
  chk_halt_cause: assert property ($rose(halt_o) |-> $past(fetch_i))
    else $error("halt without fetch");
  chk_xmem_wait: assert property ($rose(xmem_req_i) |=> xmem_wait_o)
    else $error("no wait cycle on external access");
  chk_vec_addr: assert property (!$past(rst_i) |->
    vec_addr_o == {10'h000, $past(irq_num_i), 1'b0})
    else $error("vector address not two words per vector");
endmodule : eit_trap_sva
bind eit_trap eit_trap_sva eit_trap_sva_i (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .fetch_i(fetch_i), .op_i(op_i), .pc_i(pc_i),
  .xmem_req_i(xmem_req_i), .irq_num_i(irq_num_i), .halt_o(halt_o),
  .io_clk_en_o(io_clk_en_o), .resume_o(resume_o), .xmem_wait_o(xmem_wait_o),
  .fuse_read_en_o(fuse_read_en_o), .vec_addr_o(vec_addr_o)
);
`default_nettype wire

// ### sim/eit_emu_model.sv
// Emulator controller model: signals completion a set time into each halt.
// Assumes the bench turns done_o into the Wishbone done write.
`default_nettype none
module eit_emu_model (
  input  wire logic       clk_i,
  input  wire logic       halt_i,
  input  wire logic [7:0] dly_i,
  output logic            done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt;
  // Saturating count so completion is offered once per halt
  always_ff @(posedge clk_i)
  begin
    if (!halt_i)
      cnt <= 8'h00;
    else if (cnt != 8'hff)
      cnt <= cnt + 8'h01;
  end
  assign done_o = halt_i && (cnt == dly_i);
endmodule : eit_emu_model
`default_nettype wire

// ### sim/eit_trap_tb.sv
// Self-checking bench for the extended instruction trap controller.
// Assumes a scaled hold of 20 cycles and the emulator model answering halts.
`default_nettype none
module eit_trap_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk_i = 1'b0, rst_i = 1'b1, fetch = 1'b0, xreq = 1'b0, cyc = 1'b0;
  logic        stb = 1'b0, we = 1'b0, msk = 1'b1, ack, halt, ioen, res, xw, fre, la;
  logic        sa, irq, done;
  logic [15:0] op = 16'h0000, pc = 16'h0100, vec;
  logic [7:0]  sctl = 8'h01, slock = 8'hff, adr = 8'h00, dly = 8'h20;
  logic [4:0]  irqn = 5'h00;
  logic [31:0] wdat = 32'h0, rdat, dout, ctl;
  int          num_errors = 0, num_checks = 0, seed = 32'hf0c4, k;
  logic [15:0] ops [12] = '{16'h0100, 16'h9004, 16'h9005, 16'h9006, 16'h9007, 16'h9c00,
                            16'h0200, 16'h0300, 16'h0308, 16'h0380, 16'h0388, 16'h95e8};
  logic [15:0] fld [12] = '{16'h00ff, 16'h01f0, 16'h01f0, 16'h01f0, 16'h01f0, 16'h03ff,
                            16'h00ff, 16'h0077, 16'h0077, 16'h0077, 16'h0077, 16'h0000};
  logic [7:0]  codes [4] = '{eit_pkg::PSC_FILL, eit_pkg::PSC_ERASE, eit_pkg::PSC_WRITE,
                             eit_pkg::PSC_LOCK};
  eit_trap eit_trap_i (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(1'b1), .fetch_i(fetch), .op_i(op),
    .pc_i(pc), .boot_start_i(16'h1c00), .store_ctrl_i(sctl), .store_lock_i(slock),
    .xmem_req_i(xreq), .irq_num_i(irqn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack),
    .halt_o(halt), .io_clk_en_o(ioen), .resume_o(res), .xmem_wait_o(xw),
    .fuse_read_en_o(fre), .load_allow_o(la), .store_allow_o(sa), .vec_addr_o(vec),
    .irq_o(irq));
  eit_emu_model eit_emu_model_i (.clk_i(ref_clk_i), .halt_i(halt), .dly_i(dly), .done_o(done));
  initial
  begin
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i)
  begin
    xreq <= 1'($random(seed));
    irqn <= 5'($random(seed));
  end
  task summarize;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task tmo(input logic hit);
    if (hit)
    begin
      num_errors++;
      summarize();
    end
  endtask : tmo
  // Classic cycle: request held until ack is sampled, then released
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk_i);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    for (i = 0; i < 20; i++)
    begin
      @(posedge ref_clk_i);
      if (ack)
        break;
    end
    rdat = dout;
    {cyc, stb} <= 2'b00;
    tmo(i == 20);
  endtask : wb
  task trap(input logic [15:0] o, input logic [15:0] p, input int ev);
    int i;
    dly <= 8'h18 + 8'($random(seed) & 32'h1f);
    @(posedge ref_clk_i);
    {fetch, op, pc} <= {1'b1, o, p};
    @(posedge ref_clk_i);
    fetch <= 1'b0;
    @(negedge ref_clk_i);
    chk("halt", 1, halt);
    chk("io_clk_en", 0, ioen);
    wb(1'b1, eit_pkg::ADR_CTRL, ctl | 32'h4);
    @(negedge ref_clk_i);
    chk("early_done", 1, halt);
    for (i = 0; i < 100 && !done; i++)
      @(posedge ref_clk_i);
    tmo(i == 100);
    wb(1'b1, eit_pkg::ADR_CTRL, ctl | 32'h4);
    for (i = 0; i < 20 && !res; i++)
      @(negedge ref_clk_i);
    tmo(i == 20);
    chk("halt_off", 0, halt);
    chk("io_clk_on", 1, ioen);
    @(negedge ref_clk_i);
    chk("resume_pulse", 0, res);
    chk("irq", msk, irq);
    wb(1'b0, eit_pkg::ADR_STATUS, 32'h0);
    chk("status", 1, rdat[ev]);
    wb(1'b1, eit_pkg::ADR_STATUS, 32'hf);
    @(negedge ref_clk_i);
    chk("irq_clear", 0, irq);
  endtask : trap
  initial
  begin
    ctl = 32'h0;
    repeat (8) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(negedge ref_clk_i);
    chk("rst_low", 0, {halt, res, xw, fre, sa, irq, vec});
    chk("rst_high", 3, {ioen, la});
    wb(1'b0, eit_pkg::ADR_FUSE, 32'h0);
    chk("fuse_rst", 8'hff, rdat[7:0]);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 0, rdat);
    wb(1'b1, eit_pkg::ADR_SCALE, 32'h14);
    wb(1'b1, eit_pkg::ADR_MASK, 32'hf);
    @(posedge ref_clk_i);
    {fetch, op} <= {1'b1, 16'h95c8};
    @(posedge ref_clk_i);
    fetch <= 1'b0;
    repeat (2) @(negedge ref_clk_i);
    chk("plain_load", 0, halt);
    chk("fuse_rd_off", 0, fre);
    ctl = 32'h3;
    wb(1'b1, eit_pkg::ADR_CTRL, ctl);
    @(negedge ref_clk_i);
    chk("fuse_rd_on", 1, fre);
    for (k = 0; k < 12; k++)
      trap(ops[k] | (16'($random(seed)) & fld[k]), 16'h0100, eit_pkg::EV_TRAP);
    trap(16'h95c8, 16'h0100, eit_pkg::EV_TRAP);
    msk = 1'b0;
    wb(1'b1, eit_pkg::ADR_MASK, 32'h0);
    trap(16'h0100, 16'h0100, eit_pkg::EV_TRAP);
    msk = 1'b1;
    wb(1'b1, eit_pkg::ADR_MASK, 32'hf);
    wb(1'b1, eit_pkg::ADR_FUSE, 32'hfe);
    wb(1'b0, eit_pkg::ADR_FUSE, 32'h0);
    chk("fuse_host", 8'hfe, rdat[7:0]);
    trap(16'h0000, 16'h0000, eit_pkg::EV_ZERO);
    wb(1'b1, eit_pkg::ADR_FUSE, 32'hff);
    ctl = 32'h1;
    wb(1'b1, eit_pkg::ADR_CTRL, ctl);
    trap(16'h0100, 16'h0100, eit_pkg::EV_UNSUP);
    ctl = 32'h3;
    wb(1'b1, eit_pkg::ADR_CTRL, ctl);
    for (k = 0; k < 4; k++)
    begin
      @(posedge ref_clk_i);
      {sctl, slock} <= {codes[k], 8'($random(seed))};
      trap(16'h95e8, 16'h1c10, eit_pkg::EV_TRAP);
      if (k < 3)
        chk("store_allow", 1, sa);
    end
    wb(1'b0, eit_pkg::ADR_LOCK, 32'h0);
    chk("lock_store", slock, rdat[7:0]);
    k = rdat[7:0];
    slock <= 8'h00;
    trap(16'h95e8, 16'h0100, eit_pkg::EV_TRAP);
    chk("store_allow_app", 0, sa);
    wb(1'b0, eit_pkg::ADR_LOCK, 32'h0);
    chk("store_ignored", k, rdat[7:0]);
    wb(1'b1, eit_pkg::ADR_LOCK, 32'hff);
    wb(1'b0, eit_pkg::ADR_LOCK, 32'h0);
    chk("lock_clear", 8'hff, rdat[7:0]);
    wb(1'b1, eit_pkg::ADR_LOCK, 32'hfc);
    @(negedge ref_clk_i);
    chk("general_lock", 1, la);
    summarize();
  end
endmodule : eit_trap_tb
`default_nettype wire
